/* nvsrc_dev_model.sv */
// behavioural model of the 8k x 8 sram with shadow nonvolatile array
// assumes pins change only on clk edges; times are shortened to cycles
`timescale 1ns/1ps
module nvsrc_dev_model
  import nvsrc_pkg::*;
#(
  parameter int STORE_T  = 30,
  parameter int RECALL_T = 10,
  parameter int BOOT_T   = 15
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic              cs_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              din_oe,
  output logic [DATA_W-1:0]      dout,
  input  wire logic              hw_store_busy_n,
  output logic                   hsb_pull
);
  localparam logic [12:0] SEQ [5] = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
  logic [7:0] mem [8192];
  logic [7:0] nv [8192];
  logic [7:0] last;
  logic       dirty;
  logic       st_op;
  int         busy, idx, sw_stores, recalls, hw_stores;
  wire        rd = !cs_n && !oe_n && we_n && hw_store_busy_n && busy == 0;
  // released bus shows the inverse of the last byte so a stale sample is caught
  assign dout = rd ? mem[a] : ~last;
  assign hsb_pull = busy > 0 && st_op;
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      busy <= BOOT_T;
      st_op <= 0;
      idx <= 0;
      dirty <= 0;
      last <= 0;
    end
    else if (busy > 0)
    begin
      // inputs ignored until the cycle completes
      busy <= busy - 1;
      if (busy == 1) st_op <= 0;
    end
    else if (!hw_store_busy_n)
    begin
      if (dirty)
      begin
        for (int i = 0; i < 8192; i++) nv[i] <= mem[i];
        busy <= STORE_T;
        st_op <= 1;
        dirty <= 0;
        hw_stores <= hw_stores + 1;
      end
    end
    else if (!cs_n && !we_n)
    begin
      if (din_oe) mem[a] <= din;
      dirty <= 1;
      idx <= 0;
    end
    else if (!cs_n)
    begin
      last <= mem[a];
      idx <= (idx < 5 && a == SEQ[idx]) ? idx + 1 : ((a == 13'h0000) ? 1 : 0);
      if (idx == 5 && a == SEQ_ADDR_STORE)
      begin
        for (int i = 0; i < 8192; i++) nv[i] <= mem[i];
        busy <= STORE_T;
        st_op <= 1;
        dirty <= 0;
        sw_stores <= sw_stores + 1;
      end
      if (idx == 5 && a == SEQ_ADDR_RECALL)
      begin
        for (int i = 0; i < 8192; i++) mem[i] <= nv[i];
        busy <= RECALL_T;
        recalls <= recalls + 1;
      end
    end
  // both arrays start cleared so sequence reads of unwritten cells return known data
  initial
  begin
    {sw_stores, recalls, hw_stores} <= '0;
    for (int i = 0; i < 8192; i++)
    begin
      mem[i] <= 8'h00;
      nv[i]  <= 8'h00;
    end
  end
endmodule

/* nvsrc_host_ctrl.sv */
// host controller for an 8k x 8 sram with shadow nonvolatile array
// assumes the device pins are synchronous to clk; the store/busy line is open drain
// with its pull-up resolved outside this module
//
// What this block does
// RL1: reads use chip select, output enable, strobe high
// RL2: writes use chip select and strobe low
// RL3: strobe falls before chip select on writes
// RL4: store sequence ends reading address 0F0F
// RL5: recall sequence ends reading address 0F0E
// RL6: strobe stays high through all six reads
// RL7: sequence reads drive output enable low anyway
// RL8: no other access interleaves a sequence
// RL9: data bus floats after the sixth address
// RL10: wait while a software cycle runs
// RL11: store line held low at least 250 ns
// RL12: access stays possible 1 us after line falls
// RL13: hardware store only stores written data
// RL14: no access while store line stays low
// RL15: wait 700 ns after line rises
// RL16: store line is open drain, shared
// RL17: wait 550 us power-up recall after reset
// RL18: block accesses until store or recall completes
`timescale 1ns/1ps

module nvsrc_host_ctrl
  import nvsrc_pkg::*;
#(
  parameter int STORE_CYC   = STORE_DURATION_CYC,
  parameter int POWERUP_CYC = POWERUP_RECALL_CYC
)
(
  input  wire  logic              clk,
  input  wire  logic              nrst,
  input  wire  logic              cmd_valid,
  input  wire  logic [2:0]        cmd_op,
  input  wire  logic [ADDR_W-1:0] cmd_addr,
  input  wire  logic [DATA_W-1:0] cmd_wdata,
  output logic                    cmd_ready,
  output logic                    rsp_valid,
  output logic [DATA_W-1:0]       rsp_rdata,
  output logic                    ctrl_busy,
  output logic                    written_since_store,
  output logic [ADDR_W-1:0]       address_lines,
  output logic                    chip_sel_n,
  output logic                    write_strobe_n,
  output logic                    out_enable_n,
  input  wire  logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0]       data_lines_out,
  output logic                    data_lines_oe,
  input  wire  logic              hw_store_busy_n_in,
  output logic                    hw_store_busy_n_out,
  output logic                    hw_store_busy_n_oe
);

  // ==========================================================================
  // state
  typedef struct packed
  {
    nvsrc_state_type   state;
    logic [TIMER_W-1:0] timer;
    logic [2:0]        step;
    logic              seq_recall;
    logic              op_write;
    logic              op_seq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rsp;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              dq_oe;
    logic              hsb_oe;
    logic              dirty;
  } nvsrc_regs_type;

  nvsrc_regs_type r_reg;
  nvsrc_regs_type r_next;

  // ==========================================================================
  // sequence address lookup
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step, input logic recall);
    case (step)
      3'h0:    seq_addr = SEQ_ADDR_0;
      3'h1:    seq_addr = SEQ_ADDR_1;
      3'h2:    seq_addr = SEQ_ADDR_2;
      3'h3:    seq_addr = SEQ_ADDR_3;
      3'h4:    seq_addr = SEQ_ADDR_4;
      default: seq_addr = recall ? SEQ_ADDR_RECALL : SEQ_ADDR_STORE; // RL4 RL5
    endcase
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    r_next     = r_reg;
    r_next.rsp = 1'b0;
    case (r_reg.state)
      ST_POWERUP:
      begin
        // the device recalls on its own after power-up; nothing may touch it meanwhile
        if (r_reg.timer == '0) // RL17
          r_next.state = ST_IDLE;
        else
          r_next.timer = r_reg.timer - 1'b1;
      end
      ST_IDLE:
      begin
        if (cmd_ready && cmd_valid)
        begin
          r_next.op_write = 1'b0;
          r_next.op_seq   = 1'b0;
          r_next.step     = 3'h0;
          case (cmd_op)
            OP_READ:
            begin
              r_next.addr  = cmd_addr;
              r_next.we_n  = 1'b1; // RL1
              r_next.oe_n  = 1'b0;
              r_next.state = ST_SETUP;
            end
            OP_WRITE:
            begin
              // strobe low one cycle ahead of chip select keeps the device outputs off
              r_next.addr     = cmd_addr;
              r_next.wdata    = cmd_wdata;
              r_next.op_write = 1'b1;
              r_next.we_n     = 1'b0; // RL2 RL3
              r_next.oe_n     = 1'b1;
              r_next.dq_oe    = 1'b1;
              r_next.state    = ST_SETUP;
            end
            OP_STORE, OP_RECALL:
            begin
              r_next.op_seq     = 1'b1;
              r_next.seq_recall = (cmd_op == OP_RECALL);
              r_next.addr       = seq_addr(3'h0, cmd_op == OP_RECALL);
              r_next.we_n       = 1'b1; // RL6
              r_next.oe_n       = 1'b0; // RL7
              r_next.state      = ST_SETUP;
            end
            OP_HW_STORE:
            begin
              r_next.hsb_oe = 1'b1; // RL16
              r_next.timer  = TIMER_W'(HSB_HOLD_CYC - 1);
              r_next.state  = ST_HW_ASSERT;
            end
            default:
            begin
              r_next.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_SETUP:
      begin
        r_next.ce_n  = 1'b0; // RL1 RL2
        r_next.state = ST_STROBE;
      end
      ST_STROBE:
      begin
        r_next.ce_n = 1'b1;
        if (!r_reg.op_write)
          r_next.rdata = data_lines_in;
        r_next.state = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        r_next.we_n  = 1'b1;
        r_next.oe_n  = 1'b1;
        r_next.dq_oe = 1'b0;
        if (r_reg.op_write)
          r_next.dirty = 1'b1; // RL13
        if (r_reg.op_seq)
        begin
          if (r_reg.step == 3'(SEQ_LEN - 1))
          begin
            // the bus stays floated for the whole nonvolatile cycle, far beyond the output float time
            r_next.timer = r_reg.seq_recall ? TIMER_W'(RECALL_DURATION_CYC - 1) :
                                              TIMER_W'(STORE_CYC - 1); // RL9 RL10
            if (!r_reg.seq_recall)
              r_next.dirty = 1'b0;
            r_next.state = ST_NV_WAIT;
          end
          else
          begin
            // the next sequence read follows straight away, no user command can slip in
            r_next.step  = r_reg.step + 3'h1; // RL8
            r_next.addr  = seq_addr(r_reg.step + 3'h1, r_reg.seq_recall);
            r_next.oe_n  = 1'b0; // RL7
            r_next.state = ST_SETUP;
          end
        end
        else
        begin
          r_next.rsp   = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_NV_WAIT:
      begin
        if (r_reg.timer == '0) // RL18
        begin
          r_next.rsp   = 1'b1;
          r_next.state = ST_IDLE;
        end
        else
          r_next.timer = r_reg.timer - 1'b1;
      end
      ST_HW_ASSERT:
      begin
        // held for exactly the inhibit delay so the device has taken the request before release
        if (r_reg.timer == '0) // RL11 RL12
        begin
          r_next.hsb_oe = 1'b0;
          r_next.state  = ST_HW_WAIT;
        end
        else
          r_next.timer = r_reg.timer - 1'b1;
      end
      ST_HW_WAIT:
      begin
        // the device holds the line low while storing; a skipped store lets it rise at once
        if (hw_store_busy_n_in) // RL14 RL18
        begin
          r_next.dirty = 1'b0; // RL13
          r_next.timer = TIMER_W'(INHIBIT_RELEASE_CYC - 1);
          r_next.state = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        if (r_reg.timer == '0) // RL15
        begin
          r_next.rsp   = 1'b1;
          r_next.state = ST_IDLE;
        end
        else
          r_next.timer = r_reg.timer - 1'b1;
      end
      default:
      begin
        r_next.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_reg            <= '0;
      r_reg.state      <= ST_POWERUP;
      r_reg.timer      <= TIMER_W'(POWERUP_CYC - 1);
      r_reg.ce_n       <= 1'b1;
      r_reg.we_n       <= 1'b1;
      r_reg.oe_n       <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // ==========================================================================
  // outputs
  // a line held low by any ganged device blocks new accesses here too
  assign cmd_ready           = (r_reg.state == ST_IDLE) && hw_store_busy_n_in; // RL14
  assign rsp_valid           = r_reg.rsp;
  assign rsp_rdata           = r_reg.rdata;
  assign ctrl_busy           = (r_reg.state != ST_IDLE);
  assign written_since_store = r_reg.dirty;
  assign address_lines       = r_reg.addr;
  assign chip_sel_n          = r_reg.ce_n;
  assign write_strobe_n      = r_reg.we_n;
  assign out_enable_n        = r_reg.oe_n;
  assign data_lines_out      = r_reg.wdata;
  assign data_lines_oe       = r_reg.dq_oe;
  assign hw_store_busy_n_out = 1'b0; // RL16
  assign hw_store_busy_n_oe  = r_reg.hsb_oe;

endmodule

/* nvsrc_host_ctrl_properties.sv */
// concurrent checks on the store/recall host controller pins
// assumes binding onto nvsrc_host_ctrl; one clock domain
`timescale 1ns/1ps
module nvsrc_host_ctrl_properties
  import nvsrc_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_RECALL_CYC
)
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic              chip_sel_n,
  input wire logic              write_strobe_n,
  input wire logic              out_enable_n,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic              data_lines_oe,
  input wire logic              hw_store_busy_n_in,
  input wire logic              hw_store_busy_n_oe
);
  // ==========================================================================
  // helper: edges since reset, saturating
  logic [15:0] boot_cnt_reg;
  logic [15:0] boot_cnt_next;
  always_comb boot_cnt_next = (boot_cnt_reg == 16'hFFFF) ? boot_cnt_reg : boot_cnt_reg + 16'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) boot_cnt_reg <= 16'h0;
    else boot_cnt_reg <= boot_cnt_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // properties
  chk_read_data_taken: assert property ($fell(chip_sel_n) && write_strobe_n |=>
    rsp_rdata == $past(data_lines_in)) else $error("read data not captured");
  chk_write_drives_bus: assert property (!chip_sel_n && !write_strobe_n |-> data_lines_oe)
    else $error("write without data drive");
  chk_strobe_before_sel: assert property ($fell(chip_sel_n) && !write_strobe_n |->
    $past(write_strobe_n) == 1'b0) else $error("strobe not low before select");
  chk_read_oe_low: assert property ($fell(chip_sel_n) && write_strobe_n |-> !out_enable_n)
    else $error("read without output enable");
  chk_no_access_low: assert property (!hw_store_busy_n_in |-> chip_sel_n)
    else $error("access while store line low");
  chk_hw_pulse_min: assert property ($rose(hw_store_busy_n_oe) |-> hw_store_busy_n_oe[*3])
    else $error("store request pulse too short");
  chk_recover_wait: assert property ($rose(hw_store_busy_n_in) |-> chip_sel_n[*7])
    else $error("access too soon after line rise");
  chk_powerup_wait: assert property ($fell(chip_sel_n) |-> boot_cnt_reg >= POWERUP_CYC)
    else $error("access during power-up recall");
endmodule
bind nvsrc_host_ctrl nvsrc_host_ctrl_properties #(.POWERUP_CYC(POWERUP_CYC)) u_props (.clk(clk), .nrst(nrst),
  .rsp_rdata(rsp_rdata), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
  .data_lines_in(data_lines_in), .data_lines_oe(data_lines_oe), .hw_store_busy_n_in(hw_store_busy_n_in),
  .hw_store_busy_n_oe(hw_store_busy_n_oe));

/* nvsrc_host_ctrl_tb.sv */
// self-checking bench for the store/recall host controller
// assumes the device model stands on the pins; inputs change at falling edges
`timescale 1ns/1ps
module nvsrc_host_ctrl_tb;
  import nvsrc_pkg::*;
  logic              clk = 0, nrst = 0, cmd_valid = 0;
  logic [2:0]        cmd_op = 0;
  logic [ADDR_W-1:0] cmd_addr = 0, addr;
  logic [DATA_W-1:0] cmd_wdata = 0, rdata, dout, rsp_rdata;
  logic              cmd_ready, rsp_valid, wss, cs_n, we_n, oe_n, d_oe, h_out, h_oe, pull, busy_o;
  int                bad_count = 0, cmp_count = 0, cyc = 0;
  wire               line = (h_oe ? h_out : 1'b1) & ~pull;
  always #50 clk = ~clk;
  nvsrc_host_ctrl #(.STORE_CYC(50), .POWERUP_CYC(20)) uut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .ctrl_busy(busy_o), .written_since_store(wss), .address_lines(addr), .chip_sel_n(cs_n),
    .write_strobe_n(we_n), .out_enable_n(oe_n), .data_lines_in(rdata), .data_lines_out(dout),
    .data_lines_oe(d_oe), .hw_store_busy_n_in(line), .hw_store_busy_n_out(h_out), .hw_store_busy_n_oe(h_oe));
  nvsrc_dev_model dev (.clk(clk), .nrst(nrst), .a(addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .din(dout),
    .din_oe(d_oe), .dout(rdata), .hw_store_busy_n(line), .hsb_pull(pull));
  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, op, a, d};
    @(negedge clk);
    cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
    chk({31'h0, rsp_valid}, 32'h1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_rw;
    cmd(OP_WRITE, 13'h1FFF, 8'hA5);
    cmd(OP_WRITE, 13'h0000, 8'h5A);
    cmd(OP_READ, 13'h1FFF, 8'h00);
    chk(rsp_rdata, 8'hA5);
    cmd(OP_READ, 13'h0000, 8'h00);
    chk(rsp_rdata, 8'h5A);
    chk(wss, 1'b1);
  endtask
  task automatic t_sw;
    cmd(OP_WRITE, 13'h0123, 8'h3C);
    cmd(OP_STORE, 13'h0000, 8'h00);
    chk(dev.sw_stores, 1);
    chk(wss, 1'b0);
    cmd(OP_WRITE, 13'h0123, 8'hC3);
    cmd(OP_RECALL, 13'h0000, 8'h00);
    chk(dev.recalls, 1);
    cmd(OP_READ, 13'h0123, 8'h00);
    chk(rsp_rdata, 8'h3C);
  endtask
  task automatic t_hw;
    cmd(OP_WRITE, 13'h0200, 8'h11);
    cmd(OP_HW_STORE, 13'h0000, 8'h00);
    chk(dev.hw_stores, 1);
    chk(wss, 1'b0);
    cmd(OP_HW_STORE, 13'h0000, 8'h00);
    chk(dev.hw_stores, 1);
    cmd(OP_READ, 13'h0200, 8'h00);
    chk(rsp_rdata, 8'h11);
  endtask
  // an undefined op code is swallowed: no pin activity, no response, block stays idle
  task automatic t_bad_op;
    @(negedge clk);
    {cmd_valid, cmd_op} = {1'b1, 3'h5};
    @(negedge clk);
    cmd_valid = 0;
    chk({31'h0, busy_o}, 32'h0);
    chk({31'h0, h_out}, 32'h0);
    repeat (4)
    begin
      @(negedge clk);
      chk({30'h0, rsp_valid, cs_n}, 32'h1);
    end
  endtask
  // ==========================================================================
  // main sequence and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    chk({31'h0, cmd_ready}, 32'h0);
    chk({31'h0, busy_o}, 32'h1);
    t_rw();
    t_sw();
    t_hw();
    t_bad_op();
    end_sim();
  end
endmodule

/* nvsrc_pkg.sv */
// constants shared by the nonvolatile sram store/recall host controller
// assumes a single 10 MHz clock; all pin timing is expressed in whole cycles
package nvsrc_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS           = 100;
  localparam int HW_REQUEST_MIN_PULSE_NS = 250;
  localparam int STORE_INHIBIT_DELAY_NS  = 1000;
  localparam int INHIBIT_RELEASE_TIME_NS = 700;
  localparam int DQ_FLOAT_NS             = 650;
  localparam int RECALL_DURATION_US      = 20;
  localparam int STORE_DURATION_MS       = 10;
  localparam int POWERUP_RECALL_TIME_US  = 550;

  // least times round up: the host must wait at least this long
  localparam int HW_REQUEST_MIN_PULSE_CYC = (HW_REQUEST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_INHIBIT_DELAY_CYC  = (STORE_INHIBIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INHIBIT_RELEASE_CYC      = (INHIBIT_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DQ_FLOAT_CYC             = (DQ_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_DURATION_CYC      = (RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_DURATION_CYC       = (STORE_DURATION_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_RECALL_CYC       = (POWERUP_RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the store line is held for the longer of the pulse minimum and the inhibit delay
  localparam int HSB_HOLD_CYC = (HW_REQUEST_MIN_PULSE_CYC > STORE_INHIBIT_DELAY_CYC) ?
                                HW_REQUEST_MIN_PULSE_CYC : STORE_INHIBIT_DELAY_CYC;

  // ==========================================================================
  // widths
  localparam int ADDR_W  = 13;
  localparam int DATA_W  = 8;
  localparam int TIMER_W = 20;
  localparam int SEQ_LEN = 6;

  // ==========================================================================
  // software sequence addresses
  localparam logic [12:0] SEQ_ADDR_0      = 13'h0000;
  localparam logic [12:0] SEQ_ADDR_1      = 13'h1555;
  localparam logic [12:0] SEQ_ADDR_2      = 13'h0AAA;
  localparam logic [12:0] SEQ_ADDR_3      = 13'h1FFF;
  localparam logic [12:0] SEQ_ADDR_4      = 13'h10F0;
  localparam logic [12:0] SEQ_ADDR_STORE  = 13'h0F0F;
  localparam logic [12:0] SEQ_ADDR_RECALL = 13'h0F0E;

  // ==========================================================================
  // user commands
  localparam logic [2:0] OP_READ     = 3'h0;
  localparam logic [2:0] OP_WRITE    = 3'h1;
  localparam logic [2:0] OP_STORE    = 3'h2;
  localparam logic [2:0] OP_RECALL   = 3'h3;
  localparam logic [2:0] OP_HW_STORE = 3'h4;

  typedef enum logic [3:0]
  {
    ST_POWERUP,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RELEASE,
    ST_NV_WAIT,
    ST_HW_ASSERT,
    ST_HW_WAIT,
    ST_RECOVER
  } nvsrc_state_type;

endpackage
